// ### hdl/deframer_pkg.sv
// constants, types and decoding shared by both ends of the sample link
// assumes: ref_clk at 100 MHz, link clock made by the source as ref_clk / 4
package deframer_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int unsigned PIN_W     = 32;
    localparam int unsigned PAIR_W    = 16;
    localparam int unsigned FRAME_NIB = 64;
    localparam int unsigned WORD_NIB  = 8;
    localparam int unsigned CHANS     = 4;
    localparam int unsigned SAMPLE_W  = 16;

    // ----------------------------------------------------------------
    // bus width codes, divider phases, reset stretch
    // ----------------------------------------------------------------
    localparam logic [1:0] BW_4            = 2'h0;
    localparam logic [1:0] BW_8            = 2'h1;
    localparam logic [1:0] BW_16           = 2'h2;
    localparam logic [1:0] BW_32           = 2'h3;
    localparam logic [1:0] PH_RISE_LOAD    = 2'h0;
    localparam logic [1:0] PH_FALL_LOAD    = 2'h2;
    localparam logic [5:0] LINK_RST_CYCLES = 6'h20;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] bus_width_select;
        logic       dw16;
        logic       cplx;
        logic       lvds;
    } cfg_t;

    localparam cfg_t CFG_RESET = 5'h00;

    typedef logic [FRAME_NIB-1:0][3:0]             nib_frame_t;
    typedef logic [WORD_NIB-1:0][3:0]              bus_word_t;
    typedef logic [CHANS-1:0][SAMPLE_W-1:0]        chan_t;

    // ----------------------------------------------------------------
    // decoding
    // ----------------------------------------------------------------
    function automatic logic is_ddr(cfg_t c);
        return c.lvds && (c.bus_width_select == BW_32);
    endfunction

    function automatic logic supported(cfg_t c);
        return !c.dw16 || (c.cplx && (c.bus_width_select != BW_4));
    endfunction

    function automatic logic [3:0] bus_nibbles(cfg_t c);
        return 4'h1 << c.bus_width_select;
    endfunction

    function automatic logic [5:0] frame_len(cfg_t c);
        logic [5:0] total;
        total = {1'b0, c.cplx, ~c.cplx, 3'h0} << c.dw16;
        return total >> c.bus_width_select;
    endfunction

    // first nibble of the frame carried by a bus cycle; a split term sends its upper part first
    function automatic logic [5:0] nib_base(cfg_t c, logic [5:0] cyc);
        logic [5:0] w;
        logic [5:0] d;
        w = {2'h0, bus_nibbles(c)};
        d = c.dw16 ? 6'h04 : 6'h02;
        if (w >= d) begin
            return 6'(cyc << c.bus_width_select);
        end
        return 6'({1'b0, cyc[5:1]} * d) + (cyc[0] ? 6'h00 : 6'(d - w));
    endfunction

endpackage

// ### hdl/sample_link_if.sv
// pins between the sample source and the deframer
// assumes: the source drives every signal, clock included
`timescale 1ns/100ps
interface sample_link_if;
    logic                               data_sample_clock;
    logic [deframer_pkg::PIN_W-1:0]     data_p;
    logic [deframer_pkg::PAIR_W-1:0]    data_n;
    logic                               frame_sync;

    modport source (
        output data_sample_clock,
        output data_p,
        output data_n,
        output frame_sync
    );

    modport deframer (
        input  data_sample_clock,
        input  data_p,
        input  data_n,
        input  frame_sync
    );
endinterface

// ### hdl/channelizer_input_deframer.sv
// deframer end: gathers bus words into four-channel sample sets
// assumes: link pins are synchronous to data_sample_clock, which runs free
`timescale 1ns/100ps
module channelizer_input_deframer (
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    input  wire logic [1:0]             bus_width_select,
    input  wire logic                   data_width_16,
    input  wire logic                   complex_format,
    input  wire logic                   lvds_select,
    input  wire logic                   param_update_strobe,
    output wire logic                   config_error,
    output wire logic                   frame_valid,
    output deframer_pkg::chan_t         sample_i,
    output deframer_pkg::chan_t         sample_q,
    sample_link_if.deframer             link
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LS_WAIT    = 2'b01,
        LS_COLLECT = 2'b10
    } link_state_t;

    typedef struct packed {
        logic [5:0]             hold_cnt;
        logic                   link_hold_n;
        logic                   upd_q;
        deframer_pkg::cfg_t     cfg;
        logic                   cfg_tog;
        logic [2:0]             fr_sync;
        logic                   frame_valid;
        logic                   config_error;
        deframer_pkg::chan_t    sample_i;
        deframer_pkg::chan_t    sample_q;
    } ref_st_t;

    typedef struct packed {
        logic [1:0]                 rst_sync;
        logic [2:0]                 cfg_sync;
        deframer_pkg::cfg_t         cfg;
        logic [31:0]                rise_q;
        logic                       sync_q;
        link_state_t                state;
        logic [5:0]                 frame_cycle_index;
        deframer_pkg::nib_frame_t   acc;
        deframer_pkg::nib_frame_t   hold;
        logic                       fr_tog;
    } link_st_t;

    ref_st_t                    r;
    ref_st_t                    next_r;
    link_st_t                   l;
    link_st_t                   next_l;
    logic [15:0]                fall_q;
    deframer_pkg::bus_word_t    word;
    deframer_pkg::cfg_t         cfg_in;
    logic [5:0]                 cyc;
    logic [5:0]                 base;
    logic                       take;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] term_of(deframer_pkg::nib_frame_t f, logic dw16, int k);
        if (dw16) begin
            return f[4*k +: 4];
        end
        return {8'h00, f[2*k +: 2]};
    endfunction

    function automatic logic [31:0] pin_mask(deframer_pkg::cfg_t c);
        unique case (c.bus_width_select)
            deframer_pkg::BW_4:  return 32'h0000_000F;
            deframer_pkg::BW_8:  return 32'h0000_00FF;
            deframer_pkg::BW_16: return 32'h0000_FFFF;
            deframer_pkg::BW_32: return 32'hFFFF_FFFF;
        endcase
    endfunction

    assign cfg_in.bus_width_select = bus_width_select;
    assign cfg_in.dw16             = data_width_16;
    assign cfg_in.cplx             = complex_format;
    assign cfg_in.lvds             = lvds_select;

    // ----------------------------------------------------------------
    // ref_clk side: config hand-off, link reset, frame delivery
    // ----------------------------------------------------------------
    always_comb begin
        next_r             = r;
        next_r.frame_valid = 1'b0;
        next_r.upd_q       = param_update_strobe;
        // hold the link side in reset while its clock starts up
        if (r.hold_cnt != deframer_pkg::LINK_RST_CYCLES) begin
            next_r.hold_cnt = r.hold_cnt + 6'h01;
        end else begin
            next_r.link_hold_n = 1'b1;
        end
        // new settings take effect on the rising edge of the strobe
        if (param_update_strobe && !r.upd_q) begin
            next_r.cfg          = cfg_in;
            next_r.cfg_tog      = ~r.cfg_tog;
            next_r.config_error = !deframer_pkg::supported(cfg_in);
        end
        next_r.fr_sync = {r.fr_sync[1:0], l.fr_tog};
        if (r.fr_sync[2] != r.fr_sync[1]) begin
            next_r.frame_valid = 1'b1;
            // ascending channels, in-phase before quadrature
            for (int c = 0; c < deframer_pkg::CHANS; c++) begin
                if (r.cfg.cplx) begin
                    next_r.sample_i[c] = term_of(l.hold, r.cfg.dw16, 2*c);
                    next_r.sample_q[c] = term_of(l.hold, r.cfg.dw16, 2*c + 1);
                end else begin
                    next_r.sample_i[c] = term_of(l.hold, r.cfg.dw16, c);
                    next_r.sample_q[c] = 16'h0000;
                end
            end
        end
        if (!reset_n) begin
            next_r = ref_st_t'(0);
        end
    end

    always_ff @(posedge ref_clk) begin
        r <= next_r;
    end

    // ----------------------------------------------------------------
    // link side: falling edge half of a double rate transfer
    // ----------------------------------------------------------------
    always_ff @(negedge link.data_sample_clock) begin
        fall_q <= link.data_p[deframer_pkg::PAIR_W-1:0];
    end

    // ----------------------------------------------------------------
    // link side: word assembly
    // ----------------------------------------------------------------
    always_comb begin
        next_l          = l;
        next_l.rst_sync = {l.rst_sync[0], r.link_hold_n};
        next_l.cfg_sync = {l.cfg_sync[1:0], r.cfg_tog};
        // every mode samples the pins on the rising edge
        next_l.rise_q   = link.data_p;
        next_l.sync_q   = link.frame_sync;
        // double rate joins the rise half (low) and fall half (high)
        if (deframer_pkg::is_ddr(l.cfg)) begin
            word = {fall_q, l.rise_q[15:0]};
        end else begin
            word = l.rise_q & pin_mask(l.cfg);
        end
        cyc  = (l.state == LS_WAIT) ? 6'h00 : l.frame_cycle_index;
        base = deframer_pkg::nib_base(l.cfg, cyc);
        take = (l.state == LS_COLLECT) || (l.sync_q && deframer_pkg::supported(l.cfg));
        if (take) begin
            // nibbles go to their place in the frame, by cycle and width
            for (int k = 0; k < deframer_pkg::WORD_NIB; k++) begin
                if (k < int'(deframer_pkg::bus_nibbles(l.cfg))) begin
                    next_l.acc[6'(base + 6'(k))] = word[k];
                end
            end
            // the set is handed over only after the last cycle
            if (cyc == deframer_pkg::frame_len(l.cfg) - 6'h01) begin
                next_l.hold              = next_l.acc;
                next_l.fr_tog            = ~l.fr_tog;
                next_l.state             = LS_WAIT;
                next_l.frame_cycle_index = 6'h00;
            end else begin
                next_l.state             = LS_COLLECT;
                next_l.frame_cycle_index = cyc + 6'h01;
            end
        end
        // a settings update restarts the frame
        if (l.cfg_sync[2] != l.cfg_sync[1]) begin
            next_l.cfg               = r.cfg;
            next_l.state             = LS_WAIT;
            next_l.frame_cycle_index = 6'h00;
        end
        if (!l.rst_sync[1]) begin
            next_l.cfg_sync          = 3'h0;
            next_l.cfg               = deframer_pkg::CFG_RESET;
            next_l.sync_q            = 1'b0;
            next_l.state             = LS_WAIT;
            next_l.frame_cycle_index = 6'h00;
            next_l.acc               = '0;
            next_l.hold              = '0;
            next_l.fr_tog            = 1'b0;
        end
    end

    always_ff @(posedge link.data_sample_clock) begin
        l <= next_l;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign config_error = r.config_error;
    assign frame_valid  = r.frame_valid;
    assign sample_i     = r.sample_i;
    assign sample_q     = r.sample_q;

endmodule

// ### hdl/channelizer_sample_source.sv
// source end: buffers sample sets and sends them over the link
// assumes: settings inputs are held steady while frames are queued
`timescale 1ns/100ps
module channelizer_sample_source (
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    input  wire logic [1:0]             bus_width_select,
    input  wire logic                   data_width_16,
    input  wire logic                   complex_format,
    input  wire logic                   lvds_select,
    input  wire logic                   in_valid,
    output wire logic                   in_ready,
    input  deframer_pkg::chan_t         in_i,
    input  deframer_pkg::chan_t         in_q,
    sample_link_if.source               link
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SER_IDLE = 2'b01,
        SER_SEND = 2'b10
    } ser_state_t;

    typedef struct packed {
        logic [1:0]                       phase;
        deframer_pkg::nib_frame_t [1:0]   fifo;
        logic                             wr_ptr;
        logic                             rd_ptr;
        logic [1:0]                       count;
        ser_state_t                       state;
        deframer_pkg::cfg_t               cfg;
        logic [5:0]                       frame_cycle_index;
        deframer_pkg::bus_word_t          word;
        logic [31:0]                      data_p;
        logic [15:0]                      data_n;
        logic                             frame_sync;
    } src_st_t;

    src_st_t                    s;
    src_st_t                    next_s;
    deframer_pkg::cfg_t         cfg_in;
    deframer_pkg::nib_frame_t   packed_in;
    logic                       push;
    logic                       last;
    logic                       pop_rd;
    logic [1:0]                 remain;
    logic [5:0]                 base;

    assign cfg_in.bus_width_select = bus_width_select;
    assign cfg_in.dw16             = data_width_16;
    assign cfg_in.cplx             = complex_format;
    assign cfg_in.lvds             = lvds_select;
    assign in_ready                = (s.count != 2'h2);

    // ----------------------------------------------------------------
    // buffer and serializer
    // ----------------------------------------------------------------
    always_comb begin
        next_s       = s;
        next_s.phase = s.phase + 2'h1;
        push         = in_valid && in_ready;
        // channels ascending, in-phase term before quadrature
        packed_in = '0;
        for (int c = 0; c < deframer_pkg::CHANS; c++) begin
            if (data_width_16) begin
                packed_in[4*(complex_format ? 2*c : c) +: 4] = in_i[c];
                if (complex_format) begin
                    packed_in[4*(2*c + 1) +: 4] = in_q[c];
                end
            end else begin
                packed_in[2*(complex_format ? 2*c : c) +: 2] = in_i[c][7:0];
                if (complex_format) begin
                    packed_in[2*(2*c + 1) +: 2] = in_q[c][7:0];
                end
            end
        end
        if (push) begin
            next_s.fifo[s.wr_ptr] = packed_in;
            next_s.wr_ptr         = ~s.wr_ptr;
        end
        last   = (s.state == SER_SEND) && (s.frame_cycle_index == deframer_pkg::frame_len(s.cfg) - 6'h01);
        pop_rd = 1'b0;
        remain = s.count;
        base   = 6'h00;
        if (s.phase == deframer_pkg::PH_RISE_LOAD) begin
            next_s.frame_sync = 1'b0;
            if ((s.state == SER_SEND) && !last) begin
                next_s.frame_cycle_index = s.frame_cycle_index + 6'h01;
            end else begin
                pop_rd = last;
                remain = s.count - {1'b0, last};
                if ((remain != 2'h0) && deframer_pkg::supported(cfg_in)) begin
                    next_s.state             = SER_SEND;
                    next_s.cfg               = cfg_in;
                    next_s.frame_cycle_index = 6'h00;
                    next_s.frame_sync        = 1'b1;
                end else begin
                    next_s.state = SER_IDLE;
                end
            end
            if (pop_rd) begin
                next_s.rd_ptr = ~s.rd_ptr;
            end
            next_s.word = '0;
            if (next_s.state == SER_SEND) begin
                base = deframer_pkg::nib_base(next_s.cfg, next_s.frame_cycle_index);
                // split terms go upper part first; only active pins carry data
                for (int k = 0; k < deframer_pkg::WORD_NIB; k++) begin
                    if (k < int'(deframer_pkg::bus_nibbles(next_s.cfg))) begin
                        next_s.word[k] = s.fifo[next_s.rd_ptr][6'(base + 6'(k))];
                    end
                end
            end
            // double rate sends the low half for the rising edge first
            if (deframer_pkg::is_ddr(next_s.cfg)) begin
                next_s.data_p = {16'h0000, next_s.word[3:0]};
            end else begin
                next_s.data_p = next_s.word;
            end
        end else if ((s.phase == deframer_pkg::PH_FALL_LOAD) && (s.state == SER_SEND)
                     && deframer_pkg::is_ddr(s.cfg)) begin
            next_s.data_p = {16'h0000, s.word[7:4]};
        end
        next_s.data_n = ~next_s.data_p[deframer_pkg::PAIR_W-1:0];
        next_s.count  = 2'(s.count + {1'b0, push} - {1'b0, pop_rd});
        if (!reset_n) begin
            next_s       = src_st_t'(0);
            next_s.state = SER_IDLE;
            next_s.cfg   = deframer_pkg::CFG_RESET;
            next_s.data_n = 16'hFFFF;
        end
    end

    always_ff @(posedge ref_clk) begin
        s <= next_s;
    end

    // ----------------------------------------------------------------
    // link outputs
    // ----------------------------------------------------------------
    assign link.data_sample_clock = s.phase[1];
    assign link.data_p            = s.data_p;
    assign link.data_n            = s.data_n;
    assign link.frame_sync        = s.frame_sync;

endmodule

// ### testbench/deframer_assertions.sv
// concurrent checks on the sample link and the deframer user side
// assumes: instantiated beside the link interface, one ref_clk domain
`timescale 1ns/100ps
module deframer_assertions (
    input wire logic                  ref_clk,
    input wire logic                  reset_n,
    input wire logic                  data_sample_clock,
    input wire logic [31:0]           data_p,
    input wire logic [15:0]           data_n,
    input wire logic                  frame_sync,
    input wire logic [1:0]            bus_width_select,
    input wire logic                  data_width_16,
    input wire logic                  complex_format,
    input wire logic                  param_update_strobe,
    input wire logic                  config_error,
    input wire logic                  frame_valid,
    input wire deframer_pkg::chan_t   sample_i,
    input wire deframer_pkg::chan_t   sample_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // link
    // ------------------------------------------------------------
    a_pair_complement: assert property (data_n == ~data_p[15:0])
        else $error("negative pins differ from inverted positive pins");
    a_link_clock_shape: assert property ($rose(data_sample_clock) |->
        data_sample_clock[*2] ##1 !data_sample_clock[*2] ##1 data_sample_clock)
        else $error("link clock is not ref_clk divided by four");
    a_sync_one_word: assert property ($rose(frame_sync) |-> frame_sync[*4])
        else $error("frame start marker shorter than one link cycle");

    // ------------------------------------------------------------
    // user side
    // ------------------------------------------------------------
    a_valid_one_pulse: assert property (frame_valid |=> !frame_valid)
        else $error("sample set strobe longer than one cycle");
    a_no_set_on_error: assert property (config_error |-> !frame_valid)
        else $error("sample set delivered under unsupported settings");
    a_error_decode: assert property ($rose(param_update_strobe) |-> ##[1:2]
        config_error == (data_width_16 && (!complex_format || bus_width_select == 2'h0)))
        else $error("settings error flag wrong after update");
    a_real_q_zero: assert property (frame_valid && !complex_format |-> sample_q == '0)
        else $error("quadrature output not zero for real data");
    a_samples_hold: assert property (!frame_valid |-> $stable(sample_i) && $stable(sample_q))
        else $error("sample outputs changed without a sample set strobe");
endmodule

// ### testbench/testbench.sv
// self-checking bench: source and deframer joined by the link interface
// assumes: both ends share ref_clk and reset_n; the source makes the link clock
`timescale 1ns/100ps
module testbench;
    logic                ref_clk = 1'b0;
    logic                reset_n = 1'b0;
    logic [1:0]          bus_width_select = 2'h0;
    logic                data_width_16 = 1'b0;
    logic                complex_format = 1'b0;
    logic                lvds_select = 1'b0;
    logic                param_update_strobe = 1'b0;
    logic                in_valid = 1'b0;
    logic                in_ready;
    logic                config_error;
    logic                frame_valid;
    deframer_pkg::chan_t in_i = '0;
    deframer_pkg::chan_t in_q = '0;
    deframer_pkg::chan_t sample_i;
    deframer_pkg::chan_t sample_q;
    deframer_pkg::chan_t exp_i[$], exp_q[$], got_i[$], got_q[$];
    int                  bad_count = 0;
    int                  checks_done = 0;

    sample_link_if link ();

    always #5 ref_clk = ~ref_clk;

    channelizer_sample_source i_channelizer_sample_source (.ref_clk(ref_clk), .reset_n(reset_n),
        .bus_width_select(bus_width_select), .data_width_16(data_width_16), .complex_format(complex_format),
        .lvds_select(lvds_select), .in_valid(in_valid), .in_ready(in_ready), .in_i(in_i), .in_q(in_q),
        .link(link.source));
    channelizer_input_deframer i_channelizer_input_deframer (.ref_clk(ref_clk), .reset_n(reset_n),
        .bus_width_select(bus_width_select), .data_width_16(data_width_16), .complex_format(complex_format),
        .lvds_select(lvds_select), .param_update_strobe(param_update_strobe), .config_error(config_error),
        .frame_valid(frame_valid), .sample_i(sample_i), .sample_q(sample_q), .link(link.deframer));
    deframer_assertions i_deframer_assertions (.ref_clk(ref_clk), .reset_n(reset_n),
        .data_sample_clock(link.data_sample_clock), .data_p(link.data_p), .data_n(link.data_n),
        .frame_sync(link.frame_sync), .bus_width_select(bus_width_select), .data_width_16(data_width_16),
        .complex_format(complex_format), .param_update_strobe(param_update_strobe),
        .config_error(config_error), .frame_valid(frame_valid), .sample_i(sample_i), .sample_q(sample_q));

    // ------------------------------------------------------------
    // compare, verdict, collector
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] expected);
        checks_done++;
        if (seen !== expected) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic results();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(negedge ref_clk) begin
        if (frame_valid === 1'b1) begin
            got_i.push_back(sample_i);
            got_q.push_back(sample_q);
        end
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic configure(input logic [4:0] c);
        {bus_width_select, data_width_16, complex_format, lvds_select} = c;
        param_update_strobe = 1'b0;
        repeat (2) @(negedge ref_clk);
        param_update_strobe = 1'b1;
        repeat (3) @(negedge ref_clk);
        check(64'(config_error), 64'(c[2] && (!c[1] || c[4:3] == 2'h0)));
        repeat (100) @(negedge ref_clk);
    endtask

    task automatic push(input int n);
        deframer_pkg::chan_t ei, eq;
        for (int c = 0; c < 4; c++) begin
            in_i[c] = 16'h9000 + 16'(n * 16'h0111) + 16'(c * 16'h1030);
            in_q[c] = ~in_i[c];
            ei[c] = data_width_16 ? in_i[c] : {8'h00, in_i[c][7:0]};
            eq[c] = !complex_format ? 16'h0000 : data_width_16 ? in_q[c] : {8'h00, in_q[c][7:0]};
        end
        exp_i.push_back(ei);
        exp_q.push_back(eq);
        in_valid = 1'b1;
        for (int t = 0; t < 400 && in_ready !== 1'b1; t++) @(negedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic first_word(input int n);
        logic [15:0] i0;
        i0 = 16'h9000 + 16'(n * 16'h0111);
        @(posedge link.data_sample_clock iff link.frame_sync === 1'b1);
        if (bus_width_select == 2'h0) check(64'(link.data_p[3:0]), 64'(i0[7:4]));
        if (bus_width_select == 2'h1) check(64'(link.data_p[7:0]), 64'(data_width_16 ? i0[15:8] : i0[7:0]));
        if (bus_width_select == 2'h3 && lvds_select) check(64'(link.data_p[15:0]), 64'(i0));
    endtask

    task automatic run_config(input logic [4:0] c, input int base);
        configure(c);
        fork
            first_word(base);
            begin
                for (int k = 0; k < 3; k++) begin
                    push(base + k);
                    if (k == 1) check(64'(in_ready), 64'h0);
                end
                in_valid = 1'b0;
            end
        join
        for (int t = 0; t < 2000 && got_i.size() < 3; t++) @(negedge ref_clk);
        check(64'(got_i.size()), 64'h3);
        while (got_i.size() > 0 && exp_i.size() > 0) begin
            check(got_i.pop_front(), exp_i.pop_front());
            check(got_q.pop_front(), exp_q.pop_front());
        end
        exp_i.delete();
        exp_q.delete();
        got_i.delete();
        got_q.delete();
    endtask

    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(negedge ref_clk);
        reset_n = 1'b1;
        run_config(5'h00, 0);
        run_config(5'h02, 3);
        run_config(5'h08, 6);
        run_config(5'h0A, 9);
        run_config(5'h0E, 12);
        run_config(5'h11, 15);
        run_config(5'h16, 18);
        run_config(5'h01, 30);
        run_config(5'h0B, 33);
        run_config(5'h18, 36);
        run_config(5'h1A, 21);
        run_config(5'h1F, 24);
        configure(5'h06);
        configure(5'h14);
        run_config(5'h00, 27);
        results();
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        bad_count++;
        results();
    end
endmodule
